// ---- logic/output_delay.sv ----
`default_nettype none
module output_delay
  import terminal_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             ce_i,
  input  wire logic             tick_i,
  // source and delays in ticks
  input  wire logic             src_i,
  input  wire logic [CNT_W-1:0] on_delay_i,
  input  wire logic [CNT_W-1:0] off_delay_i,
  output logic                  out_o
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] target;

  assign target = src_i ? on_delay_i : off_delay_i;

  // delay runs only while source differs from output; reverting restarts it
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
      out_o   <= 1'b0;
    end else if (ce_i) begin
      if (src_i == out_o) begin
        cnt_reg <= '0;
      end else if (target == '0) begin
        out_o <= src_i;
      end else if (tick_i) begin
        if (cnt_reg + 1'b1 >= target) begin
          out_o   <= src_i;
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

  // output only follows the source on a tick while a nonzero delay runs
  hold_filter_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && !tick_i && src_i != out_o && target != '0 |=> out_o == $past(out_o))
    else $error("output moved without a tick");
endmodule
`default_nettype wire

// ---- logic/pin_sync.sv ----
`default_nettype none
module pin_sync
  import terminal_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  // pin and settled level
  input  wire logic pin_i,
  output logic      level_o
);
  logic s1_reg, s2_reg, s3_reg;

  // three-stage chain, level accepted once stages two and three agree
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      level_o <= 1'b0;
    end else if (ce_i) begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) level_o <= s3_reg;
    end
  end
endmodule
`default_nettype wire

// ---- logic/terminal_pkg.sv ----
`default_nettype none
package terminal_pkg;
  // timing
  localparam int CLK_FREQ_HZ  = 125_000_000;
  localparam int TICK_TIME_MS = 100;
  localparam int TICK_CYCLES  = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
  localparam int CNT_W        = 16;
  // register map, index order follows REG_ADDR
  localparam int NUM_REGS = 16;
  localparam logic [15:0] REG_ADDR [NUM_REGS] = '{
    16'h1141, 16'h1142, 16'h1144, 16'h1145, 16'h1148, 16'h1149, 16'h114a, 16'h1150,
    16'h1151, 16'h1152, 16'h1153, 16'h1154, 16'h1155, 16'h1156, 16'h1157, 16'h1158};
  localparam int IDX_VOLT_SPAN   = 0;
  localparam int IDX_CUR_SPAN    = 1;
  localparam int IDX_THERM_TUNE  = 2;
  localparam int IDX_MON_OFFSET  = 3;
  localparam int IDX_DEBUG_SEL   = 4;
  localparam int IDX_SPEED_MEM   = 5;
  localparam int IDX_RESET_SEL   = 6;
  localparam int IDX_OPER_A      = 7;
  localparam int IDX_OPER_B      = 8;
  localparam int IDX_LOGIC_FN    = 9;
  localparam int IDX_DELAY_FIRST = 10;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // keypad-only communication settings window
  localparam logic [15:0] COMM_CFG_LO = 16'h1138;
  localparam logic [15:0] COMM_CFG_HI = 16'h113f;
  // option codes
  localparam logic [15:0] FN_AND      = 16'h0000;
  localparam logic [15:0] FN_OR       = 16'h0001;
  localparam logic [15:0] FN_XOR      = 16'h0002;
  localparam logic [15:0] RST_RISE    = 16'h0000;
  localparam logic [15:0] RST_FALL    = 16'h0001;
  localparam logic [15:0] RST_NOSTOP  = 16'h0002;
  localparam logic [15:0] MEM_CLEAR   = 16'h0000;
  localparam logic [15:0] MEM_KEEP    = 16'h0001;
  localparam logic [15:0] DEBUG_OFF   = 16'h0000;
  localparam logic [15:0] DEBUG_ON    = 16'h0001;
  localparam logic [15:0] OPER_B_ALT  = 16'h0002;
  localparam logic [31:0] SPAN_UNITY  = 32'h0000_03e8;
  localparam logic [15:0] SAT_MAX     = 16'hffff;
  localparam logic [15:0] SPEED_STEP  = 16'h0001;
  // register port carriers
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } reg_rsp_t;
endpackage
`default_nettype wire

// ---- logic/terminal_regs.sv ----
// Operation
// - function code 00 ANDs, 01 ORs, 02 XORs the two logic operands.
// - operand A selector takes 0 to 9, picking one internal signal.
// - operand B selector takes only 0 or 2, picking an internal signal.
// - terminal 11 turn-on delayed by 0 to 1000 tenths of a second.
// - terminal 12 turn-on delayed by 0 to 1000 tenths of a second.
// - terminals 11 and 12 each have own turn-off delay, 0.0 to 100.0 s.
// - relay energising delayed by 0 to 1000 tenths of a second.
// - relay release delayed by 0 to 1000 tenths of a second.
// - reset code 00 clears trip on rising edge, stops a running drive.
// - reset code 01 clears trip on falling edge, stops a running drive.
// - reset code 02 clears trip on rising edge, running drive unaffected.
// - memory code 00 restarts setpoint from default frequency after power cycle.
// - memory code 01 keeps last raise/lower adjusted setpoint across power cycle.
// - voltage input span scales command, 0 to 2000 at 0.1 percent.
// - current input span scales command, 0 to 2000 at 0.1 percent.
// - thermistor tuning spans 0 to 200 percent in tenths of percent.
// - monitor offset spans 0 to 100 counts of 0.1 volt.
// - debug selector is network read-only, 00 disabled, 01 enabled.
// - communication settings are unreachable from the network.
`default_nettype none
module terminal_regs
  import terminal_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // holding register port
  input  wire logic        reg_valid_i,
  input  wire reg_req_t    reg_req_i,
  output reg_rsp_t         reg_rsp_o,
  // settings logic status
  input  wire logic        debug_enable_i,
  // logic output
  input  wire logic [9:0]  status_i,
  output logic             logic_out_o,
  // delayed outputs
  input  wire logic        out11_src_i,
  input  wire logic        out12_src_i,
  input  wire logic        relay_src_i,
  output logic             out11_o,
  output logic             out12_o,
  output logic             relay_o,
  // reset terminal
  input  wire logic        reset_term_i,
  input  wire logic        running_i,
  output logic             trip_clear_o,
  output logic             drive_stop_o,
  // speed memory
  input  wire logic [1:0]  speed_raise_lower_inputs_i,
  input  wire logic        power_restore_i,
  input  wire logic [15:0] default_frequency_setting_i,
  output logic [15:0]      setpoint_o,
  // analog scaling
  input  wire logic [15:0] voltage_cmd_i,
  input  wire logic [15:0] current_analog_input_i,
  input  wire logic        current_sel_i,
  output logic [15:0]      freq_cmd_o,
  input  wire logic [15:0] thermistor_i,
  output logic [15:0]      thermistor_o,
  input  wire logic [15:0] monitor_i,
  output logic [15:0]      analog_monitor_output_o
);
  // refuse a tick too short for the delay counters
  if (TICK_LEN < 2) begin : g_tick_check
    $error("TICK_LEN must be at least 2");
  end

  logic [15:0] regs_reg [NUM_REGS];
  logic [31:0] tick_cnt_reg;
  logic        tick;
  logic        hit;
  logic [3:0]  hit_idx;
  logic        comm_cfg;
  logic        bad;
  logic        rst_lvl;
  logic        rst_prev_reg;
  logic        rise;
  logic        fall;
  logic        op_a;
  logic        op_b;
  logic        logic_next;
  logic [15:0] mem_reg;
  logic [2:0]  dly_src;
  logic [2:0]  dly_out;

  // address decode against the register table
  always_comb begin
    hit     = 1'b0;
    hit_idx = 4'h0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (reg_req_i.addr == REG_ADDR[i]) begin
        hit     = 1'b1;
        hit_idx = 4'(i);
      end
    end
  end

  assign comm_cfg = reg_req_i.addr >= COMM_CFG_LO && reg_req_i.addr <= COMM_CFG_HI;
  assign bad      = comm_cfg || !hit || (reg_req_i.wr && hit_idx == 4'(IDX_DEBUG_SEL));

  // register storage, debug selector never written from the network
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_REGS; i++) regs_reg[i] <= REG_RESET;
    end else if (ce_i && reg_valid_i && reg_req_i.wr && !bad) begin
      regs_reg[hit_idx] <= reg_req_i.wdata;
    end
  end

  // one-cycle answer, error on unmapped, keypad-only or read-only target
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rsp_o <= '0;
    end else if (ce_i) begin
      reg_rsp_o.ack   <= reg_valid_i;
      reg_rsp_o.err   <= reg_valid_i && bad;
      reg_rsp_o.rdata <= 16'h0000;
      if (reg_valid_i && !reg_req_i.wr && !bad) begin
        if (hit_idx == 4'(IDX_DEBUG_SEL))
          reg_rsp_o.rdata <= debug_enable_i ? DEBUG_ON : DEBUG_OFF;
        else
          reg_rsp_o.rdata <= regs_reg[hit_idx];
      end
    end
  end

  // 0.1 s tick for all delays
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt_reg <= '0;
    end else if (ce_i) begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h1;
    end
  end
  assign tick = tick_cnt_reg == 32'(TICK_LEN - 1);

  // operand selection and logic function
  assign op_a = regs_reg[IDX_OPER_A] <= 16'h0009 ? status_i[regs_reg[IDX_OPER_A][3:0]] : 1'b0;
  assign op_b = regs_reg[IDX_OPER_B] == OPER_B_ALT ? status_i[2] : status_i[0];

  always_comb begin
    unique case (regs_reg[IDX_LOGIC_FN])
      FN_AND:  logic_next = op_a & op_b;
      FN_OR:   logic_next = op_a | op_b;
      FN_XOR:  logic_next = op_a ^ op_b;
      default: logic_next = 1'b0;
    endcase
  end

  // registered logic output
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) logic_out_o <= 1'b0;
    else if (ce_i) logic_out_o <= logic_next;
  end

  // on/off delays for terminal 11, terminal 12 and relay
  assign dly_src = {relay_src_i, out12_src_i, out11_src_i};
  generate
    for (genvar g = 0; g < 3; g++) begin : g_dly
      output_delay u_dly (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .ce_i        (ce_i),
        .tick_i      (tick),
        .src_i       (dly_src[g]),
        .on_delay_i  (regs_reg[IDX_DELAY_FIRST + 2 * g]),
        .off_delay_i (regs_reg[IDX_DELAY_FIRST + 2 * g + 1]),
        .out_o       (dly_out[g])
      );
    end
  endgenerate
  assign out11_o = dly_out[0];
  assign out12_o = dly_out[1];
  assign relay_o = dly_out[2];

  // reset terminal pin conditioning
  pin_sync u_rst_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .pin_i     (reset_term_i),
    .level_o   (rst_lvl)
  );

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) rst_prev_reg <= 1'b0;
    else if (ce_i) rst_prev_reg <= rst_lvl;
  end
  assign rise = rst_lvl && !rst_prev_reg;
  assign fall = !rst_lvl && rst_prev_reg;

  // trip clear and stop pulses by reset behaviour code
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trip_clear_o <= 1'b0;
      drive_stop_o <= 1'b0;
    end else if (ce_i) begin
      trip_clear_o <= 1'b0;
      drive_stop_o <= 1'b0;
      unique case (regs_reg[IDX_RESET_SEL])
        RST_RISE: begin
          trip_clear_o <= rise;
          drive_stop_o <= rise && running_i;
        end
        RST_FALL: begin
          trip_clear_o <= fall;
          drive_stop_o <= fall && running_i;
        end
        RST_NOSTOP: begin
          trip_clear_o <= rise;
        end
        default: ;
      endcase
    end
  end

  // retained setpoint, updated by raise and lower inputs
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_reg <= 16'h0000;
    end else if (ce_i) begin
      if (power_restore_i)
        mem_reg <= regs_reg[IDX_SPEED_MEM] == MEM_KEEP ? mem_reg : default_frequency_setting_i;
      else if (speed_raise_lower_inputs_i == 2'b01 && setpoint_o != SAT_MAX)
        mem_reg <= setpoint_o + SPEED_STEP;
      else if (speed_raise_lower_inputs_i == 2'b10 && setpoint_o != 16'h0000)
        mem_reg <= setpoint_o - SPEED_STEP;
    end
  end

  // working setpoint, restored after a power cycle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      setpoint_o <= 16'h0000;
    end else if (ce_i) begin
      if (power_restore_i && regs_reg[IDX_SPEED_MEM] == MEM_CLEAR)
        setpoint_o <= default_frequency_setting_i;
      else if (power_restore_i)
        setpoint_o <= mem_reg;
      else if (speed_raise_lower_inputs_i == 2'b01 && setpoint_o != SAT_MAX)
        setpoint_o <= setpoint_o + SPEED_STEP;
      else if (speed_raise_lower_inputs_i == 2'b10 && setpoint_o != 16'h0000)
        setpoint_o <= setpoint_o - SPEED_STEP;
    end
  end

  // scale by a factor in tenths of a percent, saturating
  function automatic logic [15:0] scale(input logic [15:0] x, input logic [15:0] k);
    logic [31:0] p;
    p = (32'(x) * 32'(k)) / SPAN_UNITY;
    return p > 32'(SAT_MAX) ? SAT_MAX : p[15:0];
  endfunction

  // analog scaling and monitor offset
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      freq_cmd_o              <= 16'h0000;
      thermistor_o            <= 16'h0000;
      analog_monitor_output_o <= 16'h0000;
    end else if (ce_i) begin
      if (current_sel_i)
        freq_cmd_o <= scale(current_analog_input_i, regs_reg[IDX_CUR_SPAN]);
      else
        freq_cmd_o <= scale(voltage_cmd_i, regs_reg[IDX_VOLT_SPAN]);
      thermistor_o <= scale(thermistor_i, regs_reg[IDX_THERM_TUNE]);
      analog_monitor_output_o <= 17'(monitor_i) + 17'(regs_reg[IDX_MON_OFFSET]) > 17'(SAT_MAX)
                                 ? SAT_MAX : monitor_i + regs_reg[IDX_MON_OFFSET];
    end
  end

  // checks
  logic_fn_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && regs_reg[IDX_LOGIC_FN] == FN_XOR |=> logic_out_o == ($past(op_a) ^ $past(op_b)))
    else $error("xor logic output wrong");
  oper_a_sel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && regs_reg[IDX_OPER_A] == 16'h0009 && regs_reg[IDX_LOGIC_FN] == FN_AND && !status_i[9] |=> !logic_out_o)
    else $error("operand a selection wrong");
  oper_b_sel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && regs_reg[IDX_OPER_B] == OPER_B_ALT && regs_reg[IDX_LOGIC_FN] == FN_OR && status_i[2] |=> logic_out_o)
    else $error("operand b selection wrong");
  rise_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && rise && running_i && regs_reg[IDX_RESET_SEL] == RST_RISE |=> trip_clear_o && drive_stop_o)
    else $error("rising reset missed");
  fall_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && fall && regs_reg[IDX_RESET_SEL] == RST_FALL |=> trip_clear_o)
    else $error("falling reset missed");
  no_stop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    regs_reg[IDX_RESET_SEL] == RST_NOSTOP |=> !drive_stop_o)
    else $error("stop raised under code 02");
  mem_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && power_restore_i && regs_reg[IDX_SPEED_MEM] == MEM_CLEAR
    |=> setpoint_o == $past(default_frequency_setting_i))
    else $error("setpoint not reset to default");
  debug_ro_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_valid_i && reg_req_i.wr && reg_req_i.addr == REG_ADDR[IDX_DEBUG_SEL] |=> reg_rsp_o.err)
    else $error("debug selector write accepted");
  comm_block_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_valid_i && comm_cfg |=> reg_rsp_o.ack && reg_rsp_o.err)
    else $error("communication setting reachable");
  relay_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && !relay_o && relay_src_i && regs_reg[IDX_DELAY_FIRST + 4] > 16'h0001 && !tick |=> !relay_o)
    else $error("relay energised early");

  // delay filters hold while no tick arrives
  out11_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && !out11_o && out11_src_i && regs_reg[IDX_DELAY_FIRST] > 16'h0001 && !tick |=> !out11_o)
    else $error("terminal 11 on early");
  out12_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && !out12_o && out12_src_i && regs_reg[IDX_DELAY_FIRST + 2] > 16'h0001 && !tick |=> !out12_o)
    else $error("terminal 12 on early");
  out12_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && out12_o && !out12_src_i && regs_reg[IDX_DELAY_FIRST + 3] > 16'h0001 && !tick |=> out12_o)
    else $error("terminal 12 off early");
  relay_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && relay_o && !relay_src_i && regs_reg[IDX_DELAY_FIRST + 5] > 16'h0001 && !tick |=> relay_o)
    else $error("relay released early");

  // restore, scaling, debug read and falling stop
  mem_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && power_restore_i && regs_reg[IDX_SPEED_MEM] == MEM_KEEP |=> setpoint_o == $past(setpoint_o))
    else $error("kept setpoint lost");
  volt_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && !current_sel_i && regs_reg[IDX_VOLT_SPAN] == 16'h0000 |=> freq_cmd_o == 16'h0000)
    else $error("zero voltage span not zero");
  therm_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && regs_reg[IDX_THERM_TUNE] == 16'h0000 |=> thermistor_o == 16'h0000)
    else $error("zero thermistor tuning not zero");
  mon_offset_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && regs_reg[IDX_MON_OFFSET] == 16'h0000 |=> analog_monitor_output_o == $past(monitor_i))
    else $error("monitor offset applied when zero");
  debug_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && reg_valid_i && !reg_req_i.wr && reg_req_i.addr == REG_ADDR[IDX_DEBUG_SEL]
    |=> reg_rsp_o.rdata[15:1] == 15'h0000)
    else $error("debug selector read out of range");
  stop_fall_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && fall && running_i && regs_reg[IDX_RESET_SEL] == RST_FALL |=> drive_stop_o)
    else $error("falling reset stop missed");
endmodule
`default_nettype wire

// ---- test/net_master.sv ----
`default_nettype none
module net_master
  import terminal_pkg::*;
(
  // clock
  input  wire logic     clk_i,
  // holding register request and answer
  output logic          valid_o,
  output reg_req_t      req_o,
  input  wire reg_rsp_t rsp_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    valid_o = 1'b0;
    req_o   = '0;
  end
  // one word per request: one-cycle strobe, then a bounded wait for the answer
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic err);
    int n;
    @(posedge clk_i);
    valid_o <= 1'b1;
    req_o   <= '{wr: wr, addr: addr, wdata: wdata};
    @(posedge clk_i);
    valid_o <= 1'b0;
    req_o   <= ~req_o; // released bus shows no stale value
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp_i.ack !== 1'b1 && n < 4);
    rdata = rsp_i.rdata;
    err   = rsp_i.ack ? rsp_i.err : 1'bx; // missing answer never matches
  endtask
endmodule
`default_nettype wire

// ---- test/terminal_function_holding_regs_test.sv ----
`default_nettype none
module terminal_function_holding_regs_test
  import terminal_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TL = 4;
  localparam logic [15:0] WVAL [NUM_REGS] = '{16'h07d0, 16'h0064, 16'h03e8, 16'h0032, 16'h0000, 16'h0001,
    16'h0002, 16'h0009, 16'h0002, 16'h0001, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h0008};
  logic        clk_i, sys_rst_i, reg_valid_i, debug_enable_i, logic_out_o;
  reg_req_t    reg_req_i;
  reg_rsp_t    reg_rsp_o;
  logic [9:0]  status_i;
  logic        out11_src_i, out12_src_i, relay_src_i, out11_o, out12_o, relay_o;
  logic        reset_term_i, running_i, trip_clear_o, drive_stop_o, power_restore_i, current_sel_i;
  logic [1:0]  speed_raise_lower_inputs_i;
  logic [15:0] default_frequency_setting_i, setpoint_o, voltage_cmd_i, current_analog_input_i, freq_cmd_o;
  logic [15:0] thermistor_i, thermistor_o, monitor_i, analog_monitor_output_o, r;
  logic        e;
  int          bad_count, checks, cycles, trip_n, stop_n;

  terminal_regs #(.TICK_LEN(TL)) terminal_regs_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .reg_valid_i(reg_valid_i), .reg_req_i(reg_req_i),
    .reg_rsp_o(reg_rsp_o), .debug_enable_i(debug_enable_i), .status_i(status_i), .logic_out_o(logic_out_o),
    .out11_src_i(out11_src_i), .out12_src_i(out12_src_i), .relay_src_i(relay_src_i), .out11_o(out11_o),
    .out12_o(out12_o), .relay_o(relay_o), .reset_term_i(reset_term_i), .running_i(running_i),
    .trip_clear_o(trip_clear_o), .drive_stop_o(drive_stop_o),
    .speed_raise_lower_inputs_i(speed_raise_lower_inputs_i), .power_restore_i(power_restore_i),
    .default_frequency_setting_i(default_frequency_setting_i), .setpoint_o(setpoint_o),
    .voltage_cmd_i(voltage_cmd_i), .current_analog_input_i(current_analog_input_i),
    .current_sel_i(current_sel_i), .freq_cmd_o(freq_cmd_o), .thermistor_i(thermistor_i),
    .thermistor_o(thermistor_o), .monitor_i(monitor_i), .analog_monitor_output_o(analog_monitor_output_o));
  net_master net_master_i (.clk_i(clk_i), .valid_o(reg_valid_i), .req_o(reg_req_i), .rsp_i(reg_rsp_o));

  // 8 ns clock
  always #4 clk_i = ~clk_i;
  // pulse counters and hang guard
  always @(posedge clk_i) begin
    if (trip_clear_o === 1'b1) trip_n <= trip_n + 1;
    if (drive_stop_o === 1'b1) stop_n <= stop_n + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic xe);
    net_master_i.access(1'b1, a, d, r, e);
    check("write err", {15'h0, e}, {15'h0, xe});
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] xd, input logic xe);
    net_master_i.access(1'b0, a, 16'h0000, r, e);
    check("read err", {15'h0, e}, {15'h0, xe});
    check("read data", r, xd);
  endtask
  task automatic complete_run();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic outs(input string what, input int n, input logic [2:0] x);
    repeat (n) @(posedge clk_i);
    check(what, {13'h0, out11_o, out12_o, relay_o}, {13'h0, x});
  endtask

  initial begin
    {clk_i, debug_enable_i, status_i, out11_src_i, out12_src_i, relay_src_i} = '0;
    {reset_term_i, running_i, power_restore_i, current_sel_i, speed_raise_lower_inputs_i} = '0;
    {voltage_cmd_i, current_analog_input_i, thermistor_i, monitor_i} = '0;
    {bad_count, checks, cycles, trip_n, stop_n} = '0;
    default_frequency_setting_i = 16'h0100;
    sys_rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // reset values, write and read back, refusals
    for (int i = 0; i < NUM_REGS; i++) rd(REG_ADDR[i], REG_RESET, 1'b0);
    for (int i = 0; i < NUM_REGS; i++) wr(REG_ADDR[i], WVAL[i], i == IDX_DEBUG_SEL);
    for (int i = 0; i < NUM_REGS; i++) rd(REG_ADDR[i], WVAL[i], 1'b0);
    debug_enable_i <= 1'b1;
    rd(REG_ADDR[IDX_DEBUG_SEL], DEBUG_ON, 1'b0);
    rd(16'h113a, 16'h0000, 1'b1);
    wr(COMM_CFG_HI, 16'h0001, 1'b1);
    rd(16'h1143, 16'h0000, 1'b1);
    // scaling with spans 200 %, 10 %, 100 % and offset 50
    voltage_cmd_i <= 16'h0100;
    thermistor_i <= 16'h1234;
    monitor_i <= 16'h0010;
    repeat (3) @(posedge clk_i);
    check("volt scale", freq_cmd_o, 16'h0200);
    check("therm", thermistor_o, 16'h1234);
    check("monitor", analog_monitor_output_o, 16'h0042);
    voltage_cmd_i <= 16'hffff;
    repeat (3) @(posedge clk_i);
    check("volt sat", freq_cmd_o, SAT_MAX);
    current_sel_i <= 1'b1;
    current_analog_input_i <= 16'h03e8;
    repeat (3) @(posedge clk_i);
    check("cur scale", freq_cmd_o, 16'h0064);
    // speed memory, keep code then clear code
    speed_raise_lower_inputs_i <= 2'b01;
    repeat (3) @(posedge clk_i);
    speed_raise_lower_inputs_i <= 2'b10;
    @(posedge clk_i);
    speed_raise_lower_inputs_i <= 2'b00;
    power_restore_i <= 1'b1;
    @(posedge clk_i);
    power_restore_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("keep", setpoint_o, 16'h0002);
    wr(REG_ADDR[IDX_SPEED_MEM], MEM_CLEAR, 1'b0);
    power_restore_i <= 1'b1;
    @(posedge clk_i);
    power_restore_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("clear", setpoint_o, 16'h0100);
    // logic output: every function on operands A=3, B=2
    wr(REG_ADDR[IDX_OPER_A], 16'h0003, 1'b0);
    for (int f = 0; f < 3; f++) begin
      wr(REG_ADDR[IDX_LOGIC_FN], 16'(f), 1'b0);
      for (int k = 0; k < 4; k++) begin
        status_i <= {6'h0, k[1], k[0], 2'b00};
        repeat (3) @(posedge clk_i);
        check("logic fn", {15'h0, logic_out_o},
              {15'h0, f == 0 ? k[1] & k[0] : f == 1 ? k[1] | k[0] : k[1] ^ k[0]});
      end
    end
    // every operand A code, AND with operand B code 0 on bit 0
    wr(REG_ADDR[IDX_LOGIC_FN], FN_AND, 1'b0);
    wr(REG_ADDR[IDX_OPER_B], 16'h0000, 1'b0);
    for (int a = 0; a < 10; a++) begin
      wr(REG_ADDR[IDX_OPER_A], 16'(a), 1'b0);
      status_i <= (10'h1 << a) | 10'h1;
      repeat (3) @(posedge clk_i);
      check("oper a one", {15'h0, logic_out_o}, 16'h0001);
      status_i <= ~(10'h1 << a);
      repeat (3) @(posedge clk_i);
      check("oper a zero", {15'h0, logic_out_o}, 16'h0000);
    end
    // delays: on 2 ticks each, off 1, 3, 3 ticks
    for (int k = 0; k < 6; k++) wr(REG_ADDR[IDX_DELAY_FIRST + k], (k == 1) ? 16'h1 : (k[0] ? 16'h3 : 16'h2), 1'b0);
    {out11_src_i, out12_src_i, relay_src_i} <= 3'b111;
    outs("on early", 3, 3'b000);
    outs("on late", 10, 3'b111);
    {out11_src_i, out12_src_i, relay_src_i} <= 3'b000;
    outs("off split", 6, 3'b011);
    outs("off late", 10, 3'b000);
    relay_src_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    relay_src_i <= 1'b0;
    outs("glitch", 12, 3'b000);
    // reset terminal, all codes, drive running
    running_i <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      wr(REG_ADDR[IDX_RESET_SEL], 16'(c), 1'b0);
      trip_n = 0;
      stop_n = 0;
      reset_term_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      check("trip rise", 16'(trip_n), {15'h0, c != 1});
      check("stop rise", 16'(stop_n), {15'h0, c == 0});
      reset_term_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      check("trip fall", 16'(trip_n), 16'h0001);
      check("stop fall", 16'(stop_n), {15'h0, c != 2});
    end
    complete_run();
  end
endmodule
`default_nettype wire
